// >>> src/rxcfg_regs.v
// Configuration and readback register bank for the receive chain, power amplifier and gain control.
// Assumes a synchronous host port on sys_clk; the ADC code arrives from another domain.
//
// Decided for this implementation: the address-and-strobe port.
`include "rxcfg_consts.vh"
`default_nettype none

module rxcfg_regs #(
  parameter ADC_W = 6
) (
  input  wire                     sys_clk,
  input  wire                     nrst,
  input  wire [`RXCFG_AW-1:0]     reg_addr,
  input  wire [`RXCFG_DW-1:0]     reg_wdata,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  output reg  [`RXCFG_DW-1:0]     reg_rdata,
  input  wire [ADC_W-1:0]         adc_code,
  input  wire                     adc_over_full,
  input  wire [8:0]               cal_filter_tune,
  output wire [7:0]               demod_filter_width,
  output wire [8:0]               rx_filter_tune,
  output wire                     front_amp_sel,
  output wire [3:0]               rx_analog_filter_code,
  output wire [2:0]               amp_step_duration,
  output wire [4:0]               amp_bridge_bias_level,
  output reg  [3:0]               amp_output_level,
  input  wire                     amp_ramp_start,
  output wire                     amp_ramp_done,
  output wire [4:0]               ext_amp_bias_level,
  output wire                     ext_amp_dac_trim_en,
  output wire                     ext_amp_servo_trim_en,
  output wire                     ext_amp_bias_src,
  output wire                     ext_amp_supply_pin,
  output reg  [2:0]               ext_amp_bias_pin,
  output wire [1:0]               gain_hyst,
  output wire [3:0]               gain_front_thres,
  output wire                     gain_run,
  output wire [2:0]               gain_sat_offs,
  output wire [ADC_W-1:0]         gain_sat_level,
  output wire                     gain_slewing
);

  // Cycles per power step for a given rate code; rounded down, never below one
  function [31:0] step_cycles;
    input [2:0] rate;
    reg   [31:0] c;
    begin
      c = ((32'd1 << rate) * `RXCFG_STEP_TIME_PS) / `RXCFG_CLK_PS;
      step_cycles = (c == 32'd0) ? 32'd1 : c;
    end
  endfunction

  reg [7:0] demod_q, trim_low_q, trim_ctrl_q, fe_q, ramp_q, bridge_q, ext_bias_q, pwr_q, thr_q, sat_q;

  // Register writes; unmapped and read-only offsets drop the write
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      demod_q     <= `RXCFG_R_DEMOD_FILT;
      trim_low_q  <= `RXCFG_R_TRIM_LOW;
      trim_ctrl_q <= `RXCFG_R_TRIM_CTRL;
      fe_q        <= `RXCFG_R_FRONT_END;
      ramp_q      <= `RXCFG_R_RAMP;
      bridge_q    <= `RXCFG_R_BRIDGE;
      ext_bias_q  <= `RXCFG_R_EXT_BIAS;
      pwr_q       <= `RXCFG_R_PWR_MODE;
      thr_q       <= `RXCFG_R_GAIN_THR;
      sat_q       <= `RXCFG_R_GAIN_SAT;
    end else if (reg_wr) begin
      case (reg_addr)
        `RXCFG_A_DEMOD_FILT: demod_q     <= reg_wdata;
        `RXCFG_A_TRIM_LOW:   trim_low_q  <= reg_wdata;
        `RXCFG_A_TRIM_CTRL:  trim_ctrl_q <= reg_wdata;
        `RXCFG_A_FRONT_END:  fe_q        <= reg_wdata;
        `RXCFG_A_RAMP:       ramp_q      <= reg_wdata;
        `RXCFG_A_BRIDGE:     bridge_q    <= reg_wdata;
        `RXCFG_A_EXT_BIAS:   ext_bias_q  <= reg_wdata;
        `RXCFG_A_PWR_MODE:   pwr_q       <= reg_wdata;
        `RXCFG_A_GAIN_THR:   thr_q       <= reg_wdata;
        `RXCFG_A_GAIN_SAT:   sat_q       <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ADC code crosses in through three stages; taken once stages two and three agree
  reg [ADC_W-1:0] adc_s1_q, adc_s2_q, adc_s3_q, adc_q;
  reg [2:0]       ovf_sync_q;
  reg             ovf_q;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      adc_s1_q   <= {ADC_W{1'b0}};
      adc_s2_q   <= {ADC_W{1'b0}};
      adc_s3_q   <= {ADC_W{1'b0}};
      adc_q      <= {ADC_W{1'b0}};
      ovf_sync_q <= 3'h0;
      ovf_q      <= 1'b0;
    end else begin
      adc_s1_q   <= adc_code;
      adc_s2_q   <= adc_s1_q;
      adc_s3_q   <= adc_s2_q;
      ovf_sync_q <= {ovf_sync_q[1:0], adc_over_full};
      if (adc_s2_q == adc_s3_q)
        adc_q <= adc_s3_q;
      // Overload level counts only once stages two and three agree, so a glitch is not taken
      if (ovf_sync_q[1] == ovf_sync_q[2])
        ovf_q <= ovf_sync_q[2];
    end
  end

  // Read data one cycle after the strobe; upper ADC bits and unmapped offsets read zero
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `RXCFG_A_DEMOD_FILT: reg_rdata <= demod_q;
        `RXCFG_A_TRIM_LOW:   reg_rdata <= trim_low_q;
        `RXCFG_A_TRIM_CTRL:  reg_rdata <= trim_ctrl_q;
        `RXCFG_A_FRONT_END:  reg_rdata <= fe_q;
        `RXCFG_A_RAMP:       reg_rdata <= ramp_q;
        `RXCFG_A_BRIDGE:     reg_rdata <= bridge_q;
        `RXCFG_A_EXT_BIAS:   reg_rdata <= ext_bias_q;
        `RXCFG_A_PWR_MODE:   reg_rdata <= pwr_q;
        `RXCFG_A_ADC_RBK:    reg_rdata <= {{(8-ADC_W){1'b0}}, adc_q};
        `RXCFG_A_GAIN_THR:   reg_rdata <= thr_q;
        `RXCFG_A_GAIN_SAT:   reg_rdata <= sat_q;
        default:             reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Receive chain fields
  assign demod_filter_width    = demod_q;
  assign rx_filter_tune        = trim_ctrl_q[`RXCFG_F_TRIM_EN] ?
                                 {trim_ctrl_q[`RXCFG_F_TRIM_MSB], trim_low_q} : cal_filter_tune;
  assign front_amp_sel         = fe_q[`RXCFG_F_FE_SEL];
  assign rx_analog_filter_code = fe_q[3:0];

  // Amplifier static settings
  assign amp_step_duration     = ramp_q[2:0];
  assign amp_bridge_bias_level = bridge_q[4:0];
  assign ext_amp_bias_level    = ext_bias_q[4:0];
  assign ext_amp_bias_src      = pwr_q[`RXCFG_F_BIAS_SRC];

  // Bias level trims the DAC in modes 1-4 and the servo set point in modes 5-6
  wire [2:0] pin_mode = pwr_q[2:0];
  assign ext_amp_dac_trim_en   = (pin_mode >= 3'h1) && (pin_mode <= 3'h4);
  assign ext_amp_servo_trim_en = (pin_mode == 3'h5) || (pin_mode == 3'h6);

  // Pin decode; reserved code 7 parks the supply off and the bias pin floating
  assign ext_amp_supply_pin = (pin_mode != 3'h3) && (pin_mode != 3'h4) && (pin_mode != 3'h7);
  always @* begin
    case (pin_mode)
      3'h1, 3'h3: ext_amp_bias_pin = `RXCFG_PIN_SOURCE;
      3'h2, 3'h4: ext_amp_bias_pin = `RXCFG_PIN_SINK;
      3'h5:       ext_amp_bias_pin = `RXCFG_PIN_SERVO_POS;
      3'h6:       ext_amp_bias_pin = `RXCFG_PIN_SERVO_NEG;
      default:    ext_amp_bias_pin = `RXCFG_PIN_FLOAT;
    endcase
  end

  // Power ramp: steps up one level per step period until the programmed level
  localparam ST_IDLE = 2'b01;
  localparam ST_RAMP = 2'b10;
  localparam [3:0] LVL_MIN = 4'h3;
  reg [1:0]  st_q;
  reg [31:0] step_cnt_q;
  wire [3:0] target_lvl = pwr_q[7:4];
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q             <= ST_IDLE;
      step_cnt_q       <= 32'd0;
      amp_output_level <= 4'hf;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (amp_ramp_start) begin
            st_q             <= ST_RAMP;
            amp_output_level <= LVL_MIN;
            step_cnt_q       <= 32'd0;
          end else begin
            amp_output_level <= target_lvl;
          end
        end
        ST_RAMP: begin
          if (amp_output_level >= target_lvl) begin
            st_q             <= ST_IDLE;
            amp_output_level <= target_lvl;
          end else if (step_cnt_q + 32'd1 >= step_cycles(ramp_q[2:0])) begin
            step_cnt_q       <= 32'd0;
            amp_output_level <= amp_output_level + 4'h1;
          end else begin
            step_cnt_q       <= step_cnt_q + 32'd1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  assign amp_ramp_done = (st_q == ST_IDLE);

  // Gain control settings; saturation level is full scale less the offset
  assign gain_hyst        = thr_q[6:5];
  assign gain_front_thres = thr_q[4:1];
  assign gain_run         = ~thr_q[`RXCFG_F_GAIN_LOCK];
  assign gain_sat_offs    = sat_q[5:3];
  assign gain_sat_level   = {ADC_W{1'b1}} - {{(ADC_W-3){1'b0}}, sat_q[5:3]};
  assign gain_slewing     = gain_run & (ovf_q | (adc_q > gain_sat_level));

endmodule

`default_nettype wire

// >>> pkg/rxcfg_consts.vh
// Register offsets, field positions and reset values for the radio configuration bank.
// Assumes a byte-wide host port with a 10-bit address; included by bare name.
`ifndef RXCFG_CONSTS_VH
`define RXCFG_CONSTS_VH

`define RXCFG_AW              10
`define RXCFG_DW              8
// Offsets
`define RXCFG_A_DEMOD_FILT    10'h38b
`define RXCFG_A_TRIM_LOW      10'h395
`define RXCFG_A_TRIM_CTRL     10'h396
`define RXCFG_A_FRONT_END     10'h39b
`define RXCFG_A_RAMP          10'h3a7
`define RXCFG_A_BRIDGE        10'h3a8
`define RXCFG_A_EXT_BIAS      10'h3a9
`define RXCFG_A_PWR_MODE      10'h3aa
`define RXCFG_A_ADC_RBK       10'h3ae
`define RXCFG_A_GAIN_THR      10'h3b2
`define RXCFG_A_GAIN_SAT      10'h3b4
// Reset values, reserved fields at their defaults
`define RXCFG_R_DEMOD_FILT    8'hc8
`define RXCFG_R_TRIM_LOW      8'h00
`define RXCFG_R_TRIM_CTRL     8'h08
`define RXCFG_R_FRONT_END     8'h1d
`define RXCFG_R_RAMP          8'h07
`define RXCFG_R_BRIDGE        8'h0d
`define RXCFG_R_EXT_BIAS      8'h00
`define RXCFG_R_PWR_MODE      8'hf1
`define RXCFG_R_GAIN_THR      8'h30
`define RXCFG_R_GAIN_SAT      8'h90
// Field positions
`define RXCFG_F_TRIM_EN       1
`define RXCFG_F_TRIM_MSB      0
`define RXCFG_F_FE_SEL        4
`define RXCFG_F_BIAS_SRC      3
`define RXCFG_F_GAIN_LOCK     0
// Physical scale figures; the step time also sets the power ramp step period
`define RXCFG_DEMOD_STEP_KHZ  15
`define RXCFG_STEP_TIME_PS    2400
// Power amplifier step period: 2^rate * 2.4 ns, at 50 MHz in whole cycles (round down, least 1)
`define RXCFG_CLK_PS          20000
// Pin-mode codes
`define RXCFG_PIN_FLOAT       3'h0
`define RXCFG_PIN_SOURCE      3'h1
`define RXCFG_PIN_SINK        3'h2
`define RXCFG_PIN_SERVO_POS   3'h3
`define RXCFG_PIN_SERVO_NEG   3'h4

`endif

// >>> testbench/rxcfg_regs_sva.sv
// Checker for the configuration bank: host writes, pin-mode decode, ramp steps, saturation flag.
// Assumes it is bound to the bank and sees only the bank's ports on sys_clk.
`include "rxcfg_consts.vh"
`default_nettype none
module rxcfg_sva #(
  parameter int ADC_W = 6
) (
  input wire logic             sys_clk,
  input wire logic             nrst,
  input wire logic [9:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_rdata,
  input wire logic             adc_over_full,
  input wire logic [8:0]       cal_filter_tune,
  input wire logic [7:0]       demod_filter_width,
  input wire logic [8:0]       rx_filter_tune,
  input wire logic [3:0]       rx_analog_filter_code,
  input wire logic [3:0]       amp_output_level,
  input wire logic             amp_ramp_start,
  input wire logic             amp_ramp_done,
  input wire logic [2:0]       amp_step_duration,
  input wire logic             ext_amp_supply_pin,
  input wire logic             gain_run,
  input wire logic [2:0]       gain_sat_offs,
  input wire logic [ADC_W-1:0] gain_sat_level,
  input wire logic             gain_slewing
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Host write to one offset, and a ramp request taken from idle
  sequence s_wr(a);
    reg_wr && reg_addr == a;
  endsequence
  sequence s_start;
    amp_ramp_start && amp_ramp_done;
  endsequence
  // Read data must not linger, or a stale byte could be taken for a fresh read
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  AST_DEMOD_WR: assert property (s_wr(`RXCFG_A_DEMOD_FILT) |=> demod_filter_width == $past(reg_wdata))
    else $error("filter width not taken");
  AST_FE_WR: assert property (s_wr(`RXCFG_A_FRONT_END) |=> rx_analog_filter_code == $past(reg_wdata[3:0]))
    else $error("analog filter code not taken");
  AST_TRIM_ON: assert property (s_wr(`RXCFG_A_TRIM_CTRL) ##0 reg_wdata[1] |=> rx_filter_tune[8] == $past(reg_wdata[0]))
    else $error("overwrite word not applied");
  AST_TRIM_OFF: assert property (s_wr(`RXCFG_A_TRIM_CTRL) ##0 !reg_wdata[1] |=> rx_filter_tune == cal_filter_tune)
    else $error("tune word not from calibration");
  AST_SUPPLY: assert property (s_wr(`RXCFG_A_PWR_MODE) |=> ext_amp_supply_pin != ($past(reg_wdata[2:0]) inside {3'h3, 3'h4, 3'h7}))
    else $error("supply pin decode wrong");
  AST_GAIN_RUN: assert property (s_wr(`RXCFG_A_GAIN_THR) |=> gain_run == !$past(reg_wdata[0]))
    else $error("freeze bit not applied");
  AST_SAT_LVL: assert property (gain_sat_level == {ADC_W{1'b1}} - ADC_W'(gain_sat_offs))
    else $error("saturation level wrong");
  AST_SLEW: assert property ((adc_over_full && gain_run) [*5] |-> gain_slewing)
    else $error("no slewing on overload");
  AST_RAMP_START: assert property (s_start |=> amp_output_level == 4'h3 && !amp_ramp_done)
    else $error("ramp not started at minimum");
  AST_RAMP_STEP: assert property (!amp_ramp_done && amp_step_duration == 3'h0 |=>
    amp_ramp_done || amp_output_level == $past(amp_output_level) + 4'h1) else $error("ramp step timing wrong");
endmodule
bind rxcfg_regs rxcfg_sva #(.ADC_W(ADC_W)) u_sva (.*);
`default_nettype wire

// >>> testbench/tb_rxcfg_regs.sv
// Self-checking bench for the configuration bank: reset values, readback, decode, ramp, gain flags.
// Assumes the bank and its checker compile alongside; every input but cal_filter_tune, held at 9'h155, is driven here on sys_clk.
`include "rxcfg_consts.vh"
`default_nettype none
module tb_rxcfg_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, amp_ramp_start = 1'b0, adc_over_full = 1'b0;
  logic       front_amp_sel, amp_ramp_done, ext_amp_dac_trim_en, ext_amp_servo_trim_en, ext_amp_bias_src;
  logic       ext_amp_supply_pin, gain_run, gain_slewing;
  logic [1:0] gain_hyst;
  logic [2:0] amp_step_duration, ext_amp_bias_pin, gain_sat_offs;
  logic [3:0] rx_analog_filter_code, amp_output_level, gain_front_thres;
  logic [4:0] amp_bridge_bias_level, ext_amp_bias_level;
  logic [5:0] adc_code = 6'h00, gain_sat_level;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, demod_filter_width;
  logic [8:0] cal_filter_tune = 9'h155, rx_filter_tune;
  logic [9:0] reg_addr = 10'h000;
  int         n_mismatch = 0, samples_checked = 0;
  // Offsets, reset bytes and a second pattern that keeps reserved fields at their defaults
  logic [9:0] addr_t [10] = '{`RXCFG_A_DEMOD_FILT, `RXCFG_A_TRIM_LOW, `RXCFG_A_TRIM_CTRL, `RXCFG_A_FRONT_END,
    `RXCFG_A_RAMP, `RXCFG_A_BRIDGE, `RXCFG_A_EXT_BIAS, `RXCFG_A_PWR_MODE, `RXCFG_A_GAIN_THR, `RXCFG_A_GAIN_SAT};
  logic [7:0] rst_t [10] = '{8'hc8, 8'h00, 8'h08, 8'h1d, 8'h07, 8'h0d, 8'h00, 8'hf1, 8'h30, 8'h90};
  logic [7:0] new_t [10] = '{8'h85, 8'h5a, 8'h09, 8'h06, 8'h03, 8'h15, 8'h1f, 8'h3b, 8'h5f, 8'hb8};
  logic [2:0] pin_t [8] = '{3'h0, 3'h1, 3'h2, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
  rxcfg_regs dut (.*);
  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus cycles: one strobe cycle, then let the edge land before looking
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  // The converter inputs pass a synchroniser, so allow it to settle
  task automatic settle(input logic [5:0] c, input logic o);
    @(posedge sys_clk);
    adc_code <= c;
    adc_over_full <= o;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_reset();
    for (int i = 0; i < 10; i++) rd(addr_t[i], rst_t[i]);
    chk({demod_filter_width, rx_analog_filter_code, amp_step_duration, amp_output_level, gain_hyst, gain_front_thres},
      {8'hc8, 4'hd, 3'h7, 4'hf, 2'h1, 4'h8});
    chk({gain_run, gain_sat_offs, ext_amp_bias_pin, ext_amp_bias_src}, {1'b1, 3'h2, 3'h1, 1'b0});
    chk({front_amp_sel, amp_bridge_bias_level, ext_amp_bias_level}, {1'b1, 5'h0d, 5'h00});
    $display("reset test done");
  endtask
  task automatic t_rw();
    for (int i = 0; i < 10; i++) wr(addr_t[i], new_t[i]);
    wr(`RXCFG_A_ADC_RBK, 8'hff);
    wr(10'h3ff, 8'hff);
    for (int i = 0; i < 10; i++) rd(addr_t[i], new_t[i]);
    rd(10'h3ff, 8'h00);
    chk({demod_filter_width, amp_bridge_bias_level, ext_amp_bias_level, ext_amp_bias_src, amp_output_level},
      {8'h85, 5'h15, 5'h1f, 1'b1, 4'h3});
    chk({front_amp_sel, rx_analog_filter_code, amp_step_duration}, {1'b0, 4'h6, 3'h3});
    chk({gain_hyst, gain_front_thres, gain_run, gain_sat_offs, gain_sat_level},
      {2'h2, 4'hf, 1'b0, 3'h7, 6'h38});
    for (int i = 0; i < 10; i++) wr(addr_t[i], rst_t[i]);
    $display("readback test done");
  endtask
  task automatic t_trim();
    wr(`RXCFG_A_TRIM_LOW, 8'ha5);
    wr(`RXCFG_A_TRIM_CTRL, 8'h0b);
    chk(rx_filter_tune, 9'h1a5);
    wr(`RXCFG_A_TRIM_CTRL, 8'h09);
    chk(rx_filter_tune, 9'h155);
    $display("trim test done");
  endtask
  task automatic t_mode();
    for (int m = 0; m < 8; m++) begin
      wr(`RXCFG_A_PWR_MODE, 8'hf0 | 8'(m));
      chk({ext_amp_supply_pin, ext_amp_bias_pin}, {m != 3 && m != 4 && m != 7, pin_t[m]});
      chk({ext_amp_dac_trim_en, ext_amp_servo_trim_en}, {m >= 1 && m <= 4, m == 5 || m == 6});
    end
    $display("mode test done");
  endtask
  // Fastest rate steps once a cycle from minimum to the target of 5
  task automatic t_ramp();
    wr(`RXCFG_A_RAMP, 8'h00);
    wr(`RXCFG_A_PWR_MODE, 8'h51);
    @(posedge sys_clk);
    amp_ramp_start <= 1'b1;
    @(posedge sys_clk);
    amp_ramp_start <= 1'b0;
    for (int k = 3; k < 6; k++) begin
      #1;
      chk({amp_ramp_done, amp_output_level}, {1'b0, 4'(k)});
      @(posedge sys_clk);
    end
    #1;
    chk({amp_ramp_done, amp_output_level}, 5'h15);
    $display("ramp test done");
  endtask
  task automatic t_gain();
    settle(6'h3d, 1'b0);
    chk(gain_slewing, 1'b0);
    settle(6'h3e, 1'b0);
    chk(gain_slewing, 1'b1);
    rd(`RXCFG_A_ADC_RBK, 8'h3e);
    wr(`RXCFG_A_GAIN_THR, 8'h31);
    chk({gain_run, gain_slewing}, 2'h0);
    wr(`RXCFG_A_GAIN_THR, 8'h30);
    settle(6'h00, 1'b1);
    chk(gain_slewing, 1'b1);
    $display("gain test done");
  endtask
  // Second reset in mid-run must bring back the reset bytes and the idle power level
  task automatic t_rst2();
    wr(`RXCFG_A_DEMOD_FILT, 8'h21);
    wr(`RXCFG_A_PWR_MODE, 8'h51);
    @(posedge sys_clk);
    nrst <= 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b1;
    rd(`RXCFG_A_DEMOD_FILT, 8'hc8);
    rd(`RXCFG_A_PWR_MODE, 8'hf1);
    chk({amp_ramp_done, amp_output_level}, 5'h1f);
    $display("mid-run reset test done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence after a six-cycle reset
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_rw();
    t_trim();
    t_mode();
    t_ramp();
    t_gain();
    t_rst2();
    report_and_stop();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
